/* File: src/ssf_top.sv */
// i2c slave status flags with apb registers and interrupt
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssf_top (
  input  wire logic        CLK_IN,      // 25 mhz system clock
  input  wire logic        RSTN_IN,     // sync reset, low
  input  wire logic        PSEL_IN,     // apb select
  input  wire logic        PENABLE_IN,  // apb enable
  input  wire logic        PWRITE_IN,   // apb write
  input  wire logic [7:0]  PADDR_IN,    // apb byte address
  input  wire logic [31:0] PWDATA_IN,   // apb write data
  output logic      [31:0] PRDATA_OUT,  // apb read data
  output logic             PREADY_OUT,  // apb ready
  output logic             PSLVERR_OUT, // unmapped access
  input  wire logic        SCL_IN,      // i2c clock pin
  input  wire logic        SDA_IN,      // i2c data pin level
  output logic             SDA_OUT,     // data drive value
  output logic             SDA_OE_OUT,  // data drive enable
  input  wire logic        TX_EMPTY_IN, // transmit data absent
  output logic             IRQ_OUT      // interrupt, high
);
  logic [1:0]             pins_s;
  ssf_pkg::ssf_ev_t       ev;
  ssf_pkg::ssf_state_t    state_reg;
  logic [2:0]             ctrl_reg;
  logic [6:0]             id_reg [4];
  logic [6:0]             alt_reg;
  logic [2:0]             mask_reg;
  logic [2:0]             irqst_reg;
  logic [7:0]             rx_reg;
  logic                   addressed_reg;
  logic                   ack_en_reg;
  logic [1:0]             idx_reg;
  logic                   stop_reg;
  logic [1:0]             gct_reg;
  logic                   gc_reg;
  logic                   busy_reg;
  logic                   nack_reg;
  logic [3:0]             hit;
  logic [1:0]             hit_idx;
  logic                   setup;
  logic                   acc;
  logic                   wr_ctrl;
  logic                   rd_stat;
  logic                   gc_clr;
  logic                   adr_byte;
  logic                   gc2_byte;
  logic                   gc_rst;
  logic                   nack_now;
  logic [2:0]             irq_ev;
  logic [31:0]            rd_mux;
  logic                   rd_ok;
  // pins come from another clock domain
  ssf_sync #(.W(2)) u_sync (
    .clk_in  (CLK_IN),
    .rstn_in (RSTN_IN),
    .d_in    ({SCL_IN, SDA_IN}),
    .q_out   (pins_s)
  );
  ssf_bitrx u_bitrx (
    .clk_in  (CLK_IN),
    .rstn_in (RSTN_IN),
    .scl_in  (pins_s[1]),
    .sda_in  (pins_s[0]),
    .ev_out  (ev)
  );
  // address compare against all four slave address registers
  for (genvar i = 0; i < 4; i++) begin : g_hit
    assign hit[i] = id_reg[i] == ev.data[7:1];
  end
  // lowest matching register wins
  assign hit_idx = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : 2'h3;
  // apb strobes; access edge is where writes land
  assign setup    = PSEL_IN & ~PENABLE_IN;
  assign acc      = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_ctrl  = acc & PWRITE_IN & PADDR_IN == ssf_pkg::OFS_CTRL;
  assign rd_stat  = acc & ~PWRITE_IN & PADDR_IN == ssf_pkg::OFS_STATUS;
  assign gc_clr   = wr_ctrl & PWDATA_IN[ssf_pkg::CT_GC_CLR];
  assign adr_byte = ev.byte_done & state_reg == ssf_pkg::ST_ADDR;
  assign gc2_byte = ev.byte_done & state_reg == ssf_pkg::ST_GC2;
  assign gc_rst   = gc2_byte & ev.data == ssf_pkg::GC_RST_PROG;
  // nack when forced or a read finds nothing to send
  assign nack_now = ctrl_reg[ssf_pkg::CT_NACK_EN] | (ev.data[0] & TX_EMPTY_IN);
  // protocol state; a start in any state reopens the address phase
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      state_reg     <= ssf_pkg::ST_IDLE;
      addressed_reg <= 1'b0;
      ack_en_reg    <= 1'b0;
    end else if (ev.stop) begin
      state_reg     <= ssf_pkg::ST_IDLE;
      addressed_reg <= 1'b0;
      ack_en_reg    <= 1'b0;
    end else if (ev.start) begin
      state_reg  <= ssf_pkg::ST_ADDR;
      ack_en_reg <= 1'b0;
    end else if (ev.byte_done) begin
      case (state_reg)
        ssf_pkg::ST_ADDR: begin
          if (|hit) begin
            state_reg     <= ev.data[0] ? ssf_pkg::ST_IDLE : ssf_pkg::ST_WDATA;
            addressed_reg <= 1'b1;
            ack_en_reg    <= ~nack_now;
          end else if (ev.data == ssf_pkg::GC_ADDR) begin
            state_reg  <= ssf_pkg::ST_GC2;
            ack_en_reg <= 1'b1;
          end else begin
            state_reg  <= ssf_pkg::ST_IDLE;
            ack_en_reg <= 1'b0;
          end
        end
        ssf_pkg::ST_GC2: begin
          state_reg  <= ssf_pkg::ST_WDATA;
          ack_en_reg <= 1'b1;
        end
        ssf_pkg::ST_WDATA: begin
          ack_en_reg <= ~ctrl_reg[ssf_pkg::CT_NACK_EN];
        end
        default: begin
          ack_en_reg <= 1'b0;
        end
      endcase
    end
  end
  // open drain: only ever pull low, during our ack bit
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      SDA_OUT    <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else begin
      SDA_OUT    <= 1'b0;
      SDA_OE_OUT <= ev.ack_win & ack_en_reg;
    end
  end
  // software registers; a general call reset restores them too
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || gc_rst) begin
      ctrl_reg <= ssf_pkg::CTRL_RST;
      alt_reg  <= ssf_pkg::ID_RST;
      mask_reg <= ssf_pkg::IRQ_RST;
      for (int k = 0; k < 4; k++) id_reg[k] <= ssf_pkg::ID_RST;
    end else if (acc && PWRITE_IN) begin
      if (PADDR_IN == ssf_pkg::OFS_CTRL) begin
        ctrl_reg <= PWDATA_IN[2:0] & 3'h5; // clear bit never stored
      end
      if (PADDR_IN == ssf_pkg::OFS_ALT) alt_reg <= PWDATA_IN[6:0];
      if (PADDR_IN == ssf_pkg::OFS_IRQMSK) mask_reg <= PWDATA_IN[2:0];
      for (int k = 0; k < 4; k++) begin
        if (PADDR_IN == ssf_pkg::OFS_ID0 + 8'(4 * k)) id_reg[k] <= PWDATA_IN[6:0];
      end
    end
  end
  // match index, nack flag and received data
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || gc_rst) begin
      idx_reg  <= 2'h0;
      nack_reg <= 1'b0;
      rx_reg   <= 8'h00;
    end else if (adr_byte && |hit) begin
      idx_reg  <= hit_idx;
      nack_reg <= nack_now;
    end else if (adr_byte || (ev.byte_done && state_reg == ssf_pkg::ST_WDATA)) begin
      nack_reg <= 1'b0;
      if (!adr_byte) rx_reg <= ev.data;
    end else if (gc2_byte && ev.data[0]) begin
      rx_reg <= ev.data;
    end
  end
  // stop after addressed start; the stop event beats the read clear
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || gc_rst) begin
      stop_reg <= 1'b0;
    end else if (ev.stop && addressed_reg) begin
      stop_reg <= 1'b1;
    end else if (rd_stat) begin
      stop_reg <= 1'b0;
    end
  end
  // general call type and flag survive the general call reset
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      gct_reg <= ssf_pkg::GCT_NONE;
      gc_reg  <= 1'b0;
    end else if (gc2_byte) begin
      gc_reg <= 1'b1;
      if (ev.data == ssf_pkg::GC_RST_PROG) gct_reg <= ssf_pkg::GCT_RST;
      else if (ev.data == ssf_pkg::GC_PROG) gct_reg <= ssf_pkg::GCT_PROG;
      else if (ev.data[0] && ev.data[7:1] == alt_reg) gct_reg <= ssf_pkg::GCT_HW;
    end else if (gc_clr) begin
      gct_reg <= ssf_pkg::GCT_NONE;
      gc_reg  <= 1'b0;
    end
  end
  // busy from start until mismatch or stop
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || gc_rst) begin
      busy_reg <= 1'b0;
    end else if (ev.start) begin
      busy_reg <= 1'b1;
    end else if (ev.stop || (adr_byte && !(|hit) && ev.data != ssf_pkg::GC_ADDR)) begin
      busy_reg <= 1'b0;
    end
  end
  // sticky interrupt status, write one to clear, new events win
  assign irq_ev[ssf_pkg::IRQ_STOP] = ev.stop & addressed_reg & ctrl_reg[ssf_pkg::CT_STOP_IEN];
  assign irq_ev[ssf_pkg::IRQ_GC]   = gc2_byte;
  assign irq_ev[ssf_pkg::IRQ_NACK] = adr_byte & (|hit) & nack_now;

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || gc_rst) begin
      irqst_reg <= ssf_pkg::IRQ_RST;
    end else if (acc && PWRITE_IN && PADDR_IN == ssf_pkg::OFS_IRQST) begin
      irqst_reg <= (irqst_reg & ~PWDATA_IN[2:0]) | irq_ev;
    end else begin
      irqst_reg <= irqst_reg | irq_ev;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) IRQ_OUT <= 1'b0;
    else IRQ_OUT <= |(irqst_reg & mask_reg);
  end

  // read mux, captured in the setup cycle
  always_comb begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    case (PADDR_IN)
      ssf_pkg::OFS_STATUS: begin
        rd_mux[ssf_pkg::ST_IDX_LSB +: 2] = idx_reg;
        rd_mux[ssf_pkg::ST_STOP]         = stop_reg;
        rd_mux[ssf_pkg::ST_GCT_LSB +: 2] = gct_reg;
        rd_mux[ssf_pkg::ST_GC]           = gc_reg;
        rd_mux[ssf_pkg::ST_BUSY]         = busy_reg;
        rd_mux[ssf_pkg::ST_NACK]         = nack_reg;
      end
      ssf_pkg::OFS_CTRL:   rd_mux[2:0] = ctrl_reg;
      8'h08:               rd_mux[6:0] = id_reg[0];
      8'h0c:               rd_mux[6:0] = id_reg[1];
      8'h10:               rd_mux[6:0] = id_reg[2];
      8'h14:               rd_mux[6:0] = id_reg[3];
      ssf_pkg::OFS_ALT:    rd_mux[6:0] = alt_reg;
      ssf_pkg::OFS_RXDATA: rd_mux[7:0] = rx_reg;
      ssf_pkg::OFS_IRQST:  rd_mux[2:0] = irqst_reg;
      ssf_pkg::OFS_IRQMSK: rd_mux[2:0] = mask_reg;
      default:             rd_ok = 1'b0;
    endcase
  end

  // no wait states: ready is high in the first access cycle
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= ssf_pkg::RD_RST;
    end else begin
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup & ~rd_ok;
      if (setup) PRDATA_OUT <= rd_mux;
    end
  end

  sequence s_addr_hit;
    adr_byte && |hit;
  endsequence
  sequence s_gc_cmd;
    gc2_byte;
  endsequence

  property p_idx;
    @(posedge CLK_IN) disable iff (!RSTN_IN) s_addr_hit |=> idx_reg == $past(hit_idx);
  endproperty
  a_idx: assert property (p_idx) else $error("match index wrong");
  property p_idx0;
    @(posedge CLK_IN) disable iff (!RSTN_IN) s_addr_hit ##0 hit[0] |=> idx_reg == 2'h0;
  endproperty
  a_idx0: assert property (p_idx0) else $error("first match not zero");
  property p_stop;
    @(posedge CLK_IN) disable iff (!RSTN_IN) ev.stop && addressed_reg |=> stop_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag not set");
  property p_irq;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      irq_ev[0] && mask_reg[0] && !gc_rst |=> ##1 IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("stop irq missing");
  property p_rdclr;
    @(posedge CLK_IN) disable iff (!RSTN_IN) rd_stat && !ev.stop |=> !stop_reg;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear");
  property p_gcrst;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      s_gc_cmd ##0 gc_rst |=> gct_reg == 2'h1 && gc_reg && ctrl_reg == 3'h0;
  endproperty
  a_gcrst: assert property (p_gcrst) else $error("general call reset wrong");
  property p_gcclr;
    @(posedge CLK_IN) disable iff (!RSTN_IN) gc_clr && !gc2_byte |=> gct_reg == 2'h0 && !gc_reg;
  endproperty
  a_gcclr: assert property (p_gcclr) else $error("clear failed");
  property p_gcset;
    @(posedge CLK_IN) disable iff (!RSTN_IN) s_gc_cmd |=> gc_reg;
  endproperty
  a_gcset: assert property (p_gcset) else $error("general call flag unset");
  property p_gchold;
    @(posedge CLK_IN) disable iff (!RSTN_IN) gc_reg && !gc_clr |=> gc_reg;
  endproperty
  a_gchold: assert property (p_gchold) else $error("general call flag lost");
  property p_busy;
    @(posedge CLK_IN) disable iff (!RSTN_IN) ev.start |=> busy_reg;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");
  property p_idle;
    @(posedge CLK_IN) disable iff (!RSTN_IN) ev.stop |=> !busy_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("busy not cleared");
  property p_nack;
    @(posedge CLK_IN) disable iff (!RSTN_IN) s_addr_hit |=> nack_reg == $past(nack_now);
  endproperty
  a_nack: assert property (p_nack) else $error("nack flag wrong");
endmodule : ssf_top
`default_nettype wire

/* File: src/ssf_pkg.sv */
// shared constants and types of the slave status flag block
package ssf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_ID0    = 8'h08;
  localparam logic [7:0] OFS_ALT    = 8'h18;
  localparam logic [7:0] OFS_RXDATA = 8'h1c;
  localparam logic [7:0] OFS_IRQST  = 8'h20;
  localparam logic [7:0] OFS_IRQMSK = 8'h24;
  // slave_status field positions
  localparam int ST_IDX_LSB = 11;
  localparam int ST_STOP    = 10;
  localparam int ST_GCT_LSB = 8;
  localparam int ST_GC      = 7;
  localparam int ST_BUSY    = 6;
  localparam int ST_NACK    = 5;
  // slave_control field positions
  localparam int CT_STOP_IEN = 0;
  localparam int CT_GC_CLR   = 1;
  localparam int CT_NACK_EN  = 2;
  // irq status and mask bit positions
  localparam int IRQ_STOP = 0;
  localparam int IRQ_GC   = 1;
  localparam int IRQ_NACK = 2;
  // reset values
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [6:0]  ID_RST   = 7'h00;
  localparam logic [2:0]  IRQ_RST  = 3'h0;
  localparam logic [31:0] RD_RST   = 32'h0;
  // general call codes and types; ack bit counter values
  localparam logic [7:0] GC_ADDR     = 8'h00;
  localparam logic [7:0] GC_RST_PROG = 8'h06;
  localparam logic [7:0] GC_PROG     = 8'h04;
  localparam logic [1:0] GCT_NONE    = 2'h0;
  localparam logic [1:0] GCT_RST     = 2'h1;
  localparam logic [1:0] GCT_PROG    = 2'h2;
  localparam logic [1:0] GCT_HW      = 2'h3;
  localparam logic [3:0] ACK_BIT     = 4'h8;
  localparam logic [3:0] ACK_DONE    = 4'h9;
  // protocol states of the slave
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ADDR  = 2'b01,
    ST_GC2   = 2'b10,
    ST_WDATA = 2'b11
  } ssf_state_t;
  // bus events from the bit receiver
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       byte_done;
    logic       ack_win;
    logic [7:0] data;
  } ssf_ev_t;
endpackage : ssf_pkg

/* File: src/ssf_sync.sv */
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssf_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_in,  // system clock
  input  wire logic         rstn_in, // sync reset, low
  input  wire logic [W-1:0] d_in,    // async inputs
  output logic      [W-1:0] q_out    // synchronised
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second; idle bus level is high
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_reg <= '1;
      q_out    <= '1;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : ssf_sync
`default_nettype wire

/* File: src/ssf_bitrx.sv */
// start, stop and byte framing from sampled scl and sda
`timescale 1ns/1ps
`default_nettype none
module ssf_bitrx (
  input  wire logic        clk_in,  // system clock
  input  wire logic        rstn_in, // sync reset, low
  input  wire logic        scl_in,  // synchronised scl
  input  wire logic        sda_in,  // synchronised sda
  output ssf_pkg::ssf_ev_t ev_out   // bus events
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt_reg;
  logic [7:0] shf_reg;
  logic       rise;
  logic       fall;

  assign rise = scl_in & ~scl_q;
  assign fall = ~scl_in & scl_q;

  // edge history of the two lines
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // bit counter: 0..7 data, 8 ack bit, 9 ack sampled
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_reg <= 4'h0;
      shf_reg <= 8'h00;
    end else if (scl_in && scl_q && sda_q != sda_in) begin
      cnt_reg <= 4'h0; // start or stop restarts framing
    end else if (rise && cnt_reg < ssf_pkg::ACK_DONE) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg < ssf_pkg::ACK_BIT) shf_reg <= {shf_reg[6:0], sda_in};
    end else if (fall && cnt_reg == ssf_pkg::ACK_DONE) begin
      cnt_reg <= 4'h0;
    end
  end

  // one cycle event pulses plus the ack window level
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ev_out <= '0;
    end else begin
      ev_out.start     <= scl_in & scl_q & sda_q & ~sda_in;
      ev_out.stop      <= scl_in & scl_q & ~sda_q & sda_in;
      ev_out.byte_done <= rise && cnt_reg == 4'h7;
      ev_out.data      <= {shf_reg[6:0], sda_in};
      if (fall && cnt_reg == ssf_pkg::ACK_BIT) ev_out.ack_win <= 1'b1;
      else if ((fall && cnt_reg == ssf_pkg::ACK_DONE) || scl_q && sda_q != sda_in)
        ev_out.ack_win <= 1'b0;
    end
  end
endmodule : ssf_bitrx
`default_nettype wire

/* File: tb/ssf_i2c_master.sv */
// behavioural i2c bus master driving scl and pulling sda low
`timescale 1ns/1ps
`default_nettype none
module ssf_i2c_master (
  output logic      scl_out,     // bus clock, idle high
  output logic      sda_low_out, // high pulls sda low
  input  wire logic sda_in       // resolved sda level
);
  // both lines rest high between frames, clock stands still
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // start: sda falls while scl is high; scl period is 320 ns
  task automatic start();
    #7 sda_low_out = 1'b1;
    #160 scl_out = 1'b0;
  endtask : start
  // data moves well after scl fall so the slave hold time is kept
  task automatic put_bit(input logic b);
    #40 sda_low_out = ~b;
    #120 scl_out = 1'b1;
    #160 scl_out = 1'b0;
  endtask : put_bit
  // byte msb first, then release sda and sample the ack mid high;
  // the leading step keeps line changes off the system clock edge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    #7;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    #40 sda_low_out = 1'b0;
    #120 scl_out = 1'b1;
    #80 ack = (sda_in == 1'b0);
    #80 scl_out = 1'b0;
  endtask : wbyte
  // stop: sda rises while scl is high
  task automatic stop();
    #47 sda_low_out = 1'b1;
    #120 scl_out = 1'b1;
    #160 sda_low_out = 1'b0;
    #160;
  endtask : stop
endmodule : ssf_i2c_master
`default_nettype wire

/* File: tb/ssf_top_test.sv */
// self-checking bench of the slave status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t value mismatch", $time); end end
module ssf_top_test;
  logic        clk, rstn, psel, penable, pwrite, txe, scl, sda_low, sda_line, ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rs;
  logic        pready, pslverr, sda_o, sda_oe, irq;
  logic [67:0] notes[$];
  logic [67:0] nt;
  logic [6:0]  ids[4];
  logic [6:0]  alt;
  logic [2:0]  nk_tab[3] = '{3'b110, 3'b101, 3'b000};
  int          error_cnt = 0;
  int          cmp_count = 0;
  // open drain sda with pull-up: low if any party pulls
  assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
  ssf_top DUT (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .TX_EMPTY_IN(txe), .IRQ_OUT(irq));
  ssf_i2c_master m (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_line));
  // 25 mhz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;
  function automatic logic [31:0] lfsr_step(input logic [31:0] x);
    lfsr_step = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_step
  function automatic logic [31:0] st(input logic [1:0] ix, input logic sp,
                                     input logic [1:0] gt, input logic gc, input logic by);
    st = 32'h0;
    st[ssf_pkg::ST_IDX_LSB +: 2] = ix;
    st[ssf_pkg::ST_STOP] = sp;
    st[ssf_pkg::ST_GCT_LSB +: 2] = gt;
    st[ssf_pkg::ST_GC] = gc;
    st[ssf_pkg::ST_BUSY] = by;
  endfunction : st
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // one apb transfer; the note {expect, mask} covers irq, error and read data
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [33:0] e, input logic [33:0] k);
    int n;
    notes.push_back({e, k});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 34'h0, {2'b01, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] k);
    xfer(a, 1'b0, 32'h0, e, {2'b11, k});
  endtask : rd
  task automatic gcall(input logic [7:0] b);
    m.start();
    m.wbyte(8'h00, ack);
    m.wbyte(b, ack);
    m.stop();
  endtask : gcall
  // watcher: each completed transfer is compared with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      `CHK({irq, pslverr, prdata} & nt[33:0], nt[67:34] & nt[33:0])
    end
  end
  // hang guard
  initial begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; txe = 1'b0; rs = 32'h0fc8c82d;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ssf_pkg::OFS_STATUS, 34'h0, 32'hffffffff);
    rs = lfsr_step(rs);
    xfer(8'hfc, 1'b0, 32'h0, {2'b01, 32'h0}, {2'b11, 32'hffffffff});
    xfer(8'hfc, 1'b1, rs, {2'b01, 32'h0}, {2'b01, 32'h0});
    wr(ssf_pkg::OFS_CTRL, 32'h1 << ssf_pkg::CT_STOP_IEN);
    wr(ssf_pkg::OFS_IRQMSK, 32'h1 << ssf_pkg::IRQ_STOP);
    // distinct random slave addresses, top bit set to stay clear of general call
    rs = lfsr_step(rs);
    for (int i = 0; i < 4; i++) begin
      ids[i] = {1'b1, rs[3:0], i[1:0]};
      wr(ssf_pkg::OFS_ID0 + 8'(4 * i), {25'h0, ids[i]});
    end
    for (int i = 0; i < 4; i++) begin
      m.start();
      m.wbyte({ids[i], 1'b0}, ack);
      `CHK(ack, 1'b1)
      rd(ssf_pkg::OFS_STATUS, {2'b00, st(i[1:0], '0, '0, '0, '1)}, 32'h1fe0);
      rs = lfsr_step(rs);
      m.wbyte(rs[7:0], ack);
      m.stop();
      rd(ssf_pkg::OFS_STATUS, {2'b10, st(i[1:0], '1, '0, '0, '0)}, 32'h1fe0);
      rd(ssf_pkg::OFS_STATUS, {2'b10, st(i[1:0], '0, '0, '0, '0)}, 32'h1fe0);
      wr(ssf_pkg::OFS_IRQST, 32'h1 << ssf_pkg::IRQ_STOP);
    end
    // address that matches no register
    m.start();
    m.wbyte({1'b0, rs[12:8], 1'b1, 1'b0}, ack);
    `CHK(ack, 1'b0)
    rd(ssf_pkg::OFS_STATUS, 34'h0, 32'h40);
    m.stop();
    rd(ssf_pkg::OFS_STATUS, 34'h0, 32'h440);
    // nack cases: forced, transmit empty, neither
    for (int k = 0; k < 3; k++) begin
      wr(ssf_pkg::OFS_CTRL, {29'h0, nk_tab[k][1], 2'b01});
      @(posedge clk);
      txe <= nk_tab[k][0];
      m.start();
      m.wbyte({ids[1], 1'b1}, ack);
      m.stop();
      `CHK(ack, ~nk_tab[k][2])
      // a matched read address still counts as addressed, so the stop irq is pending
      rd(ssf_pkg::OFS_STATUS, {1'b1, 27'h0, nk_tab[k][2], 5'h0}, 32'h20);
    end
    wr(ssf_pkg::OFS_IRQST, 32'h7);
    // general call kinds, clear and reset side effects
    gcall(ssf_pkg::GC_PROG);
    rd(ssf_pkg::OFS_STATUS, {2'b00, st('0, '0, ssf_pkg::GCT_PROG, '1, '0)}, 32'h380);
    rd(ssf_pkg::OFS_STATUS, {2'b00, st('0, '0, ssf_pkg::GCT_PROG, '1, '0)}, 32'h380);
    gcall(ssf_pkg::GC_RST_PROG);
    rd(ssf_pkg::OFS_STATUS, {2'b00, st('0, '0, ssf_pkg::GCT_RST, '1, '0)}, 32'h380);
    rd(ssf_pkg::OFS_ID0, 34'h0, 32'h7f);
    rd(ssf_pkg::OFS_CTRL, 34'h0, 32'h7);
    rd(ssf_pkg::OFS_IRQMSK, 34'h0, 32'h7);
    wr(ssf_pkg::OFS_CTRL, 32'h1 << ssf_pkg::CT_GC_CLR);
    rd(ssf_pkg::OFS_STATUS, 34'h0, 32'h380);
    rs = lfsr_step(rs);
    alt = {1'b0, rs[5:1], 1'b1};
    wr(ssf_pkg::OFS_ALT, {25'h0, alt});
    // the general call reset zeroed the slave addresses, which would catch address zero
    for (int i = 0; i < 4; i++) wr(ssf_pkg::OFS_ID0 + 8'(4 * i), {25'h0, ids[i]});
    gcall({alt, 1'b1});
    rd(ssf_pkg::OFS_STATUS, {2'b00, st('0, '0, ssf_pkg::GCT_HW, '1, '0)}, 32'h380);
    rd(ssf_pkg::OFS_RXDATA, {26'h0, alt, 1'b1}, 32'hff);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : ssf_top_test
`default_nettype wire
